// ### design/rtm_pkg.sv
// Package of constants and types for the tag memory access command handler
package rtm_pkg;
  localparam int ADDR_W = 8;
  localparam int ID_W = 64;
  localparam int MEM_DEPTH = 256;
  localparam logic [7:0] VALID_ADDR_MAX = 8'hDF;
  localparam logic [7:0] PORT_STATUS = 8'h00;
  localparam int PORT_XBIT = 0;
  localparam int PORT_OKBIT = 1;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam int MASK_B0 = 7;
  localparam real TPROG_MS = 13.3;
  localparam real CLK_NS = 10.0;
  localparam int PROG_CYCLES = int'((TPROG_MS * 1.0e6 + CLK_NS - 1.0)
    / CLK_NS);

  typedef enum logic [3:0] {
    RTM_CMD_VERIFY_BYTE = 4'h0,
    RTM_CMD_VERIFY_QUAD = 4'h1,
    RTM_CMD_READ_PORT = 4'h2,
    RTM_CMD_WRITE = 4'h3,
    RTM_CMD_QUAD_PROG = 4'h4,
    RTM_CMD_LOCK = 4'h5,
    RTM_CMD_LOCK_QUERY = 4'h6,
    RTM_CMD_BCAST_WRITE = 4'h7,
    RTM_CMD_REINIT = 4'h8
  } rtm_cmd_e;

  typedef enum logic [1:0] {
    RTM_ST_READY = 2'h0,
    RTM_ST_IDENT = 2'h1,
    RTM_ST_XFER = 2'h2
  } rtm_state_e;

  typedef enum logic [2:0] {
    RTM_RSP_DATA = 3'h0,
    RTM_RSP_ACK = 3'h1,
    RTM_RSP_ERROR = 3'h2,
    RTM_RSP_ACK_OK = 3'h3,
    RTM_RSP_ACK_NOK = 3'h4,
    RTM_RSP_LOCKED_OK = 3'h5,
    RTM_RSP_LOCKED_NOK = 3'h6
  } rtm_rsp_e;

  typedef struct packed {
    rtm_cmd_e op;
    logic [ID_W-1:0] id;
    logic [ADDR_W-1:0] addr;
    logic [7:0] mask;
    logic [31:0] data;
    logic crc_ok;
  } rtm_cmd_s;

  typedef struct packed {
    rtm_rsp_e kind;
    logic [2:0] nbytes;
    logic [31:0] data;
  } rtm_rsp_s;
endpackage

// ### design/rtm_handler.sv
// Tag memory access command handler
`timescale 1ns/10ps
module rtm_handler #(
  parameter int PROG_CYCLES = rtm_pkg::PROG_CYCLES,
  parameter logic [rtm_pkg::ID_W-1:0] TAG_ID = 64'h0123_4567_89AB_CDEF
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire rtm_pkg::rtm_cmd_s cmd,
  input wire logic ident_enter,
  output logic rsp_valid,
  output rtm_pkg::rtm_rsp_s rsp,
  output logic busy,
  output logic [1:0] tag_state,
  output logic [7:0] tag_status_port
);
  // TAG_ID value is arbitrary.
  localparam int AW = rtm_pkg::ADDR_W;
  localparam logic [31:0] PROG_LAST = 32'(PROG_CYCLES - 1);

  typedef enum logic [1:0] {
    RTM_P_IDLE = 2'h0,
    RTM_P_WAIT = 2'h1
  } rtm_prog_e;

  logic [7:0] mem [rtm_pkg::MEM_DEPTH];
  logic [rtm_pkg::MEM_DEPTH-1:0] lock_reg;
  rtm_pkg::rtm_state_e state_reg;
  logic ok_reg;
  logic xbit_reg;
  logic lockable_v_reg;
  logic [AW-1:0] lockable_a_reg;
  rtm_prog_e prog_reg;
  logic [31:0] pcnt_reg;
  logic [AW-1:0] paddr_reg;
  logic [31:0] pdata_reg;
  logic [3:0] pen_reg;
  logic plock_reg;

  function automatic logic [AW-1:0] addr_off(input logic [AW-1:0] a,
                                             input int k);
    addr_off = a + AW'(k);
  endfunction

  function automatic logic quad_locked(input logic [AW-1:0] a,
      input logic [rtm_pkg::MEM_DEPTH-1:0] lk);
    logic r;
    r = 1'b0;
    for (int k = 0; k < 4; k++) begin
      r = r | lk[addr_off(a, k)];
    end
    quad_locked = r;
  endfunction

  logic take;
  logic id_match;
  logic byte_locked;
  logic lock_ok;
  logic valid_addr;
  logic [7:0] port_val;

  assign take = cmd_valid && cmd.crc_ok && prog_reg == RTM_P_IDLE;
  assign id_match = cmd.id == TAG_ID;
  assign byte_locked = lock_reg[cmd.addr];
  assign valid_addr = cmd.addr <= rtm_pkg::VALID_ADDR_MAX;
  assign lock_ok = valid_addr && lockable_v_reg
    && lockable_a_reg == cmd.addr;
  assign busy = prog_reg != RTM_P_IDLE;
  assign tag_state = state_reg;

  always_comb begin
    port_val = rtm_pkg::PORT_RESET;
    port_val[rtm_pkg::PORT_XBIT] = xbit_reg;
    port_val[rtm_pkg::PORT_OKBIT] = ok_reg;
  end
  assign tag_status_port = port_val;

  // Protocol state and exchange status bit
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= rtm_pkg::RTM_ST_READY;
      xbit_reg <= 1'b0;
    end else if (take) begin
      unique case (cmd.op)
        rtm_pkg::RTM_CMD_REINIT: begin
          state_reg <= rtm_pkg::RTM_ST_READY;
          xbit_reg <= 1'b0;
        end
        rtm_pkg::RTM_CMD_VERIFY_BYTE, rtm_pkg::RTM_CMD_VERIFY_QUAD: begin
          if (id_match && ok_reg) begin
            state_reg <= rtm_pkg::RTM_ST_XFER;
            xbit_reg <= 1'b1;
          end
        end
        rtm_pkg::RTM_CMD_READ_PORT, rtm_pkg::RTM_CMD_WRITE,
        rtm_pkg::RTM_CMD_QUAD_PROG, rtm_pkg::RTM_CMD_LOCK_QUERY: begin
          if (id_match) begin
            state_reg <= rtm_pkg::RTM_ST_XFER;
            xbit_reg <= 1'b1;
          end
        end
        rtm_pkg::RTM_CMD_LOCK, rtm_pkg::RTM_CMD_BCAST_WRITE: begin
        end
        // Unknown opcodes leave the state alone
        default: begin
        end
      endcase
    end else if (ident_enter && state_reg == rtm_pkg::RTM_ST_READY) begin
      state_reg <= rtm_pkg::RTM_ST_IDENT;
    end
  end

  // Response generation
  always_ff @(posedge mclk) begin
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp <= '0;
    end else begin
      rsp_valid <= 1'b0;
      if (take && id_match) begin
        unique case (cmd.op)
          rtm_pkg::RTM_CMD_VERIFY_BYTE: begin
            if (ok_reg) begin
              rsp_valid <= 1'b1;
              rsp <= '{rtm_pkg::RTM_RSP_DATA, 3'h1,
                {24'h000000, mem[cmd.addr]}};
            end
          end
          rtm_pkg::RTM_CMD_VERIFY_QUAD: begin
            if (ok_reg) begin
              rsp_valid <= 1'b1;
              rsp <= '{rtm_pkg::RTM_RSP_DATA, 3'h4,
                {mem[cmd.addr], mem[addr_off(cmd.addr, 1)],
                 mem[addr_off(cmd.addr, 2)], mem[addr_off(cmd.addr, 3)]}};
            end
          end
          rtm_pkg::RTM_CMD_READ_PORT: begin
            rsp_valid <= 1'b1;
            rsp <= '{rtm_pkg::RTM_RSP_DATA, 3'h1, {24'h000000,
              (cmd.addr == rtm_pkg::PORT_STATUS) ? port_val : 8'h00}};
          end
          rtm_pkg::RTM_CMD_WRITE: begin
            rsp_valid <= 1'b1;
            rsp <= '{byte_locked ? rtm_pkg::RTM_RSP_ERROR
              : rtm_pkg::RTM_RSP_ACK, 3'h1, 32'h00000000};
          end
          rtm_pkg::RTM_CMD_QUAD_PROG: begin
            rsp_valid <= 1'b1;
            rsp <= '{quad_locked(cmd.addr, lock_reg)
              ? rtm_pkg::RTM_RSP_ERROR : rtm_pkg::RTM_RSP_ACK,
              3'h1, 32'h00000000};
          end
          rtm_pkg::RTM_CMD_LOCK: begin
            if (state_reg == rtm_pkg::RTM_ST_XFER) begin
              rsp_valid <= 1'b1;
              rsp <= '{lock_ok ? rtm_pkg::RTM_RSP_ACK
                : rtm_pkg::RTM_RSP_ACK_NOK, 3'h1, 32'h00000000};
            end
          end
          rtm_pkg::RTM_CMD_LOCK_QUERY: begin
            rsp_valid <= 1'b1;
            if (byte_locked) begin
              rsp <= '{ok_reg ? rtm_pkg::RTM_RSP_LOCKED_OK
                : rtm_pkg::RTM_RSP_LOCKED_NOK, 3'h1, 32'h00000000};
            end else begin
              rsp <= '{ok_reg ? rtm_pkg::RTM_RSP_ACK_OK
                : rtm_pkg::RTM_RSP_ACK_NOK, 3'h1, 32'h00000000};
            end
          end
          rtm_pkg::RTM_CMD_BCAST_WRITE, rtm_pkg::RTM_CMD_REINIT: begin
          end
          // Unknown opcodes get no reply
          default: begin
          end
        endcase
      end
    end
  end

  // Lockable tracking: one candidate byte
  always_ff @(posedge mclk) begin
    if (reset) begin
      lockable_v_reg <= 1'b0;
      lockable_a_reg <= '0;
    end else if (take && id_match && (cmd.op == rtm_pkg::RTM_CMD_WRITE
        || cmd.op == rtm_pkg::RTM_CMD_LOCK_QUERY
        || (cmd.op == rtm_pkg::RTM_CMD_VERIFY_BYTE && ok_reg))) begin
      lockable_v_reg <= 1'b1;
      lockable_a_reg <= cmd.addr;
    end else if (take && id_match
        && cmd.op == rtm_pkg::RTM_CMD_QUAD_PROG) begin
      lockable_v_reg <= 1'b0;
    end
  end

  // Programming sequencer: response first, then timed write
  always_ff @(posedge mclk) begin
    if (reset) begin
      prog_reg <= RTM_P_IDLE;
      pcnt_reg <= '0;
      paddr_reg <= '0;
      pdata_reg <= '0;
      pen_reg <= '0;
      plock_reg <= 1'b0;
    end else if (prog_reg == RTM_P_WAIT) begin
      pcnt_reg <= pcnt_reg + 32'h00000001;
      if (pcnt_reg == PROG_LAST) begin
        prog_reg <= RTM_P_IDLE;
      end
    end else if (take) begin
      pcnt_reg <= '0;
      paddr_reg <= cmd.addr;
      pdata_reg <= cmd.data;
      plock_reg <= 1'b0;
      unique case (cmd.op)
        rtm_pkg::RTM_CMD_WRITE: begin
          if (id_match && !byte_locked) begin
            prog_reg <= RTM_P_WAIT;
            pen_reg <= 4'h8;
            pdata_reg <= {cmd.data[7:0], 24'h000000};
          end
        end
        rtm_pkg::RTM_CMD_BCAST_WRITE: begin
          if (state_reg != rtm_pkg::RTM_ST_READY && !byte_locked) begin
            prog_reg <= RTM_P_WAIT;
            pen_reg <= 4'h8;
            pdata_reg <= {cmd.data[7:0], 24'h000000};
          end
        end
        rtm_pkg::RTM_CMD_QUAD_PROG: begin
          if (id_match && !quad_locked(cmd.addr, lock_reg)) begin
            prog_reg <= RTM_P_WAIT;
            pen_reg <= cmd.mask[rtm_pkg::MASK_B0 -: 4];
          end
        end
        rtm_pkg::RTM_CMD_LOCK: begin
          if (id_match && state_reg == rtm_pkg::RTM_ST_XFER && lock_ok) begin
            prog_reg <= RTM_P_WAIT;
            plock_reg <= 1'b1;
            pen_reg <= 4'h0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Nonvolatile array update at end of programming time
  always_ff @(posedge mclk) begin
    if (prog_reg == RTM_P_WAIT && pcnt_reg == PROG_LAST) begin
      for (int k = 0; k < 4; k++) begin
        if (pen_reg[3-k]) begin
          mem[addr_off(paddr_reg, k)] <= pdata_reg[31-8*k -: 8];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      lock_reg <= '0;
    end else if (prog_reg == RTM_P_WAIT && pcnt_reg == PROG_LAST
        && plock_reg) begin
      lock_reg[paddr_reg] <= 1'b1;
    end
  end

  // Write success flag
  always_ff @(posedge mclk) begin
    if (reset) begin
      ok_reg <= 1'b0;
    end else if (take) begin
      unique case (cmd.op)
        rtm_pkg::RTM_CMD_WRITE: begin
          if (id_match) begin
            ok_reg <= !byte_locked;
          end
        end
        rtm_pkg::RTM_CMD_QUAD_PROG: begin
          if (id_match) begin
            ok_reg <= !quad_locked(cmd.addr, lock_reg);
          end
        end
        rtm_pkg::RTM_CMD_LOCK: begin
          if (id_match && state_reg == rtm_pkg::RTM_ST_XFER) begin
            ok_reg <= lock_ok;
          end
        end
        rtm_pkg::RTM_CMD_BCAST_WRITE: begin
          if (state_reg != rtm_pkg::RTM_ST_READY) begin
            ok_reg <= !byte_locked;
          end
        end
        default: begin
        end
      endcase
    end
  end
endmodule

// ### tb/rtm_handler_props.sv
// Checker of reply, refusal and status behaviour of the command handler
`timescale 1ns/10ps
module rtm_handler_props #(
  parameter logic [rtm_pkg::ID_W-1:0] TAG_ID = '0
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire rtm_pkg::rtm_cmd_s cmd,
  input wire logic ident_enter,
  input wire logic rsp_valid,
  input wire rtm_pkg::rtm_rsp_s rsp,
  input wire logic busy,
  input wire logic [1:0] tag_state,
  input wire logic [7:0] tag_status_port
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  logic take;
  assign take = cmd_valid && cmd.crc_ok && !busy;
  reply_cause_a: assert property (rsp_valid |-> $past(take))
    else $error("reply without an accepted command");
  crc_drop_a: assert property (cmd_valid && !cmd.crc_ok |=> !rsp_valid)
    else $error("reply to a command with bad check");
  id_drop_a: assert property (cmd_valid && cmd.id != TAG_ID
      |=> !rsp_valid)
    else $error("reply to a foreign identifier");
  silent_ops_a: assert property (cmd_valid &&
      (cmd.op == rtm_pkg::RTM_CMD_BCAST_WRITE ||
       cmd.op == rtm_pkg::RTM_CMD_REINIT) |=> !rsp_valid)
    else $error("reply to a silent command");
  reinit_idle_a: assert property (take &&
      cmd.op == rtm_pkg::RTM_CMD_REINIT && !ident_enter |=>
      tag_state == rtm_pkg::RTM_ST_READY && !tag_status_port[0])
    else $error("reinit left state or exchange bit");
  verify_byte_a: assert property (rsp_valid &&
      $past(cmd.op) == rtm_pkg::RTM_CMD_VERIFY_BYTE |->
      $past(tag_status_port[1]) && rsp.nbytes == 3'h1 &&
      rsp.kind == rtm_pkg::RTM_RSP_DATA)
    else $error("bad verify byte reply");
  verify_quad_a: assert property (rsp_valid &&
      $past(cmd.op) == rtm_pkg::RTM_CMD_VERIFY_QUAD |->
      $past(tag_status_port[1]) && rsp.nbytes == 3'h4)
    else $error("bad verify quad reply");
  port_read_a: assert property (rsp_valid &&
      $past(cmd.op) == rtm_pkg::RTM_CMD_READ_PORT |->
      tag_state == rtm_pkg::RTM_ST_XFER && rsp.data[31:2] == 30'h0)
    else $error("bad port read reply");
  port_rsvd_a: assert property (tag_status_port[7:2] == 6'h00)
    else $error("reserved port bits set");
  ack_busy_a: assert property (rsp_valid &&
      rsp.kind == rtm_pkg::RTM_RSP_ACK |-> busy ##1 busy)
    else $error("acknowledge not followed by programming");
  query_flag_a: assert property (rsp_valid &&
      $past(cmd.op) == rtm_pkg::RTM_CMD_LOCK_QUERY |->
      (rsp.kind == rtm_pkg::RTM_RSP_ACK_OK ||
       rsp.kind == rtm_pkg::RTM_RSP_LOCKED_OK) == $past(tag_status_port[1]))
    else $error("lock query reply disagrees with flag");
  error_flag_a: assert property (rsp_valid &&
      rsp.kind == rtm_pkg::RTM_RSP_ERROR |-> !tag_status_port[1])
    else $error("error reply left success flag set");
  busy_quiet_a: assert property (busy |=> !rsp_valid)
    else $error("reply while programming");
endmodule

bind rtm_handler rtm_handler_props #(.TAG_ID(TAG_ID)) rtm_handler_props_inst (
  .mclk(mclk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd),
  .ident_enter(ident_enter), .rsp_valid(rsp_valid), .rsp(rsp), .busy(busy),
  .tag_state(tag_state), .tag_status_port(tag_status_port));

// ### tb/rtm_reader.sv
// Interrogator model issuing decoded commands and catching replies
`timescale 1ns/10ps
module rtm_reader (
  input wire logic mclk,
  output logic cmd_valid,
  output rtm_pkg::rtm_cmd_s cmd,
  input wire logic rsp_valid,
  input wire rtm_pkg::rtm_rsp_s rsp
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  task automatic send(input rtm_pkg::rtm_cmd_s c, output logic got,
      output rtm_pkg::rtm_rsp_s r);
    if (c.op == rtm_pkg::RTM_CMD_QUAD_PROG) c.addr[1:0] = 2'h0;
    @(negedge mclk);
    cmd = c;
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
    // Released bus shows no stale command
    cmd = ~c;
    got = rsp_valid;
    r = rsp;
  endtask
endmodule

// ### tb/test_rtm_handler.sv
// Self-checking bench for the command handler
`timescale 1ns/10ps
module test_rtm_handler;
  // Identifier value is arbitrary
  localparam logic [63:0] TID = 64'h5A5A_0F0F_3C3C_9696;
  logic mclk, reset, ident_enter, rsp_valid, busy, cmd_valid, got;
  rtm_pkg::rtm_cmd_s cmd;
  rtm_pkg::rtm_rsp_s rsp, r;
  logic [1:0] tag_state;
  logic [7:0] tag_status_port;
  int mismatches = 0, checks_done = 0, cycles = 0;
  rtm_handler #(.PROG_CYCLES(4), .TAG_ID(TID)) rtm_handler_inst (
    .mclk(mclk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd),
    .ident_enter(ident_enter), .rsp_valid(rsp_valid), .rsp(rsp),
    .busy(busy), .tag_state(tag_state), .tag_status_port(tag_status_port));
  rtm_reader rtm_reader_inst (.mclk(mclk), .cmd_valid(cmd_valid),
    .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic chk(input string what, input logic [31:0] e,
      input logic [31:0] a);
    checks_done++;
    if (a !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, e, a);
    end
  endtask
  task automatic chk_status(input logic [7:0] ep, input logic [1:0] es);
    chk("status port", {24'h0, ep}, {24'h0, tag_status_port});
    chk("state", {30'h0, es}, {30'h0, tag_state});
  endtask
  // f: bit0 foreign identifier, bit1 failed check
  task automatic xfer(input rtm_pkg::rtm_cmd_e op, input logic [7:0] a,
      input logic [7:0] m, input logic [31:0] d, input logic [1:0] f,
      input logic want, input rtm_pkg::rtm_rsp_e k, input logic [31:0] ed);
    rtm_pkg::rtm_cmd_s c;
    c = '{op, f[0] ? ~TID : TID, a, m, d, !f[1]};
    rtm_reader_inst.send(c, got, r);
    chk("reply", {31'h0, want}, {31'h0, got});
    if (want && got === 1'b1) begin
      chk("kind", {29'h0, k}, {29'h0, r.kind});
      chk("data", ed, r.data);
    end
  endtask
  task automatic idle;
    while (busy !== 1'b0) @(negedge mclk);
  endtask
  initial begin
    reset = 1'b1;
    ident_enter = 1'b0;
    repeat (6) @(negedge mclk);
    reset = 1'b0;
    chk_status(8'h00, 2'h0);
    xfer(rtm_pkg::RTM_CMD_VERIFY_BYTE, 8'h10, 8'h00, 32'h0,
      2'h0, 1'b0, rtm_pkg::RTM_RSP_DATA, 32'h0);
    xfer(rtm_pkg::RTM_CMD_WRITE, 8'h10, 8'h00, 32'hA5,
      2'h1, 1'b0, rtm_pkg::RTM_RSP_ACK, 32'h0);
    xfer(rtm_pkg::RTM_CMD_WRITE, 8'h10, 8'h00, 32'hA5,
      2'h2, 1'b0, rtm_pkg::RTM_RSP_ACK, 32'h0);
    chk_status(8'h00, 2'h0);
    $display("test refusals done");
    xfer(rtm_pkg::RTM_CMD_WRITE, 8'h10, 8'h00, 32'hA5,
      2'h0, 1'b1, rtm_pkg::RTM_RSP_ACK, 32'h0);
    chk("busy", 32'h1, {31'h0, busy});
    xfer(rtm_pkg::RTM_CMD_READ_PORT, 8'h00, 8'h00, 32'h0,
      2'h0, 1'b0, rtm_pkg::RTM_RSP_DATA, 32'h0);
    idle();
    chk_status(8'h03, 2'h2);
    xfer(rtm_pkg::RTM_CMD_READ_PORT, 8'h00, 8'h00, 32'h0,
      2'h0, 1'b1, rtm_pkg::RTM_RSP_DATA, 32'h3);
    xfer(rtm_pkg::RTM_CMD_READ_PORT, 8'h01, 8'h00, 32'h0,
      2'h0, 1'b1, rtm_pkg::RTM_RSP_DATA, 32'h0);
    xfer(rtm_pkg::RTM_CMD_VERIFY_BYTE, 8'h10, 8'h00, 32'h0,
      2'h0, 1'b1, rtm_pkg::RTM_RSP_DATA, 32'hA5);
    xfer(rtm_pkg::RTM_CMD_LOCK, 8'h10, 8'h00, 32'h0,
      2'h0, 1'b1, rtm_pkg::RTM_RSP_ACK, 32'h0);
    idle();
    xfer(rtm_pkg::RTM_CMD_LOCK_QUERY, 8'h10, 8'h00, 32'h0,
      2'h0, 1'b1, rtm_pkg::RTM_RSP_LOCKED_OK, 32'h0);
    xfer(rtm_pkg::RTM_CMD_WRITE, 8'h10, 8'h00, 32'h5A,
      2'h0, 1'b1, rtm_pkg::RTM_RSP_ERROR, 32'h0);
    idle();
    chk_status(8'h01, 2'h2);
    xfer(rtm_pkg::RTM_CMD_VERIFY_BYTE, 8'h10, 8'h00, 32'h0,
      2'h0, 1'b0, rtm_pkg::RTM_RSP_DATA, 32'h0);
    xfer(rtm_pkg::RTM_CMD_LOCK_QUERY, 8'h10, 8'h00, 32'h0,
      2'h0, 1'b1, rtm_pkg::RTM_RSP_LOCKED_NOK, 32'h0);
    xfer(rtm_pkg::RTM_CMD_LOCK_QUERY, 8'h11, 8'h00, 32'h0,
      2'h0, 1'b1, rtm_pkg::RTM_RSP_ACK_NOK, 32'h0);
    xfer(rtm_pkg::RTM_CMD_LOCK, 8'hE0, 8'h00, 32'h0,
      2'h0, 1'b1, rtm_pkg::RTM_RSP_ACK_NOK, 32'h0);
    xfer(rtm_pkg::RTM_CMD_LOCK, 8'h12, 8'h00, 32'h0,
      2'h0, 1'b1, rtm_pkg::RTM_RSP_ACK_NOK, 32'h0);
    $display("test byte and lock done");
    xfer(rtm_pkg::RTM_CMD_QUAD_PROG, 8'h20, 8'hF0, 32'h55667788,
      2'h0, 1'b1, rtm_pkg::RTM_RSP_ACK, 32'h0);
    idle();
    xfer(rtm_pkg::RTM_CMD_QUAD_PROG, 8'h20, 8'h90, 32'h11223344,
      2'h0, 1'b1, rtm_pkg::RTM_RSP_ACK, 32'h0);
    idle();
    xfer(rtm_pkg::RTM_CMD_VERIFY_QUAD, 8'h20, 8'h00, 32'h0,
      2'h0, 1'b1, rtm_pkg::RTM_RSP_DATA, 32'h11667744);
    xfer(rtm_pkg::RTM_CMD_LOCK_QUERY, 8'h11, 8'h00, 32'h0,
      2'h0, 1'b1, rtm_pkg::RTM_RSP_ACK_OK, 32'h0);
    xfer(rtm_pkg::RTM_CMD_QUAD_PROG, 8'h10, 8'hF0, 32'h0,
      2'h0, 1'b1, rtm_pkg::RTM_RSP_ERROR, 32'h0);
    idle();
    chk_status(8'h01, 2'h2);
    $display("test quad done");
    xfer(rtm_pkg::RTM_CMD_BCAST_WRITE, 8'h24, 8'h00, 32'h9A,
      2'h0, 1'b0, rtm_pkg::RTM_RSP_ACK, 32'h0);
    idle();
    xfer(rtm_pkg::RTM_CMD_VERIFY_BYTE, 8'h24, 8'h00, 32'h0,
      2'h0, 1'b1, rtm_pkg::RTM_RSP_DATA, 32'h9A);
    xfer(rtm_pkg::RTM_CMD_VERIFY_BYTE, 8'h10, 8'h00, 32'h0,
      2'h0, 1'b1, rtm_pkg::RTM_RSP_DATA, 32'hA5);
    xfer(rtm_pkg::RTM_CMD_REINIT, 8'h00, 8'h00, 32'h0,
      2'h0, 1'b0, rtm_pkg::RTM_RSP_ACK, 32'h0);
    chk_status(8'h02, 2'h0);
    xfer(rtm_pkg::RTM_CMD_BCAST_WRITE, 8'h24, 8'h00, 32'h00,
      2'h0, 1'b0, rtm_pkg::RTM_RSP_ACK, 32'h0);
    idle();
    ident_enter = 1'b1;
    @(negedge mclk);
    ident_enter = 1'b0;
    chk_status(8'h02, 2'h1);
    xfer(rtm_pkg::RTM_CMD_VERIFY_BYTE, 8'h24, 8'h00, 32'h0,
      2'h0, 1'b1, rtm_pkg::RTM_RSP_DATA, 32'h9A);
    $display("test broadcast and reinit done");
    // Reset in mid-run clears flags, reply and lock bits
    reset = 1'b1;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    chk_status(8'h00, 2'h0);
    chk("reset reply", 32'h0, rsp.data);
    xfer(rtm_pkg::RTM_CMD_LOCK_QUERY, 8'h10, 8'h00, 32'h0,
      2'h0, 1'b1, rtm_pkg::RTM_RSP_ACK_NOK, 32'h0);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule
